/* design/eps_status_regs.sv */
// Purpose: exposure, pixel readout and part code registers
// Assumes: frame_tick and pixel stream come from the core on clk
// Notes: the serial framing is outside; reg_* are already decoded accesses
`timescale 1ns/100ps
`default_nettype none
module eps_status_regs (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // core image stream
  input  wire logic                 frame_tick,
  input  wire logic [5:0]           frame_max,
  input  wire logic                 sample_strobe,
  input  wire logic [8:0]           sample_index,
  input  wire logic [5:0]           sample_code,
  // register access
  input  wire logic                 reg_read,
  input  wire logic                 reg_write,
  input  wire logic [7:0]           reg_addr,
  output logic [7:0]                reg_rdata,
  // exposure state
  output logic [15:0]               exposure
);
  import eps_pkg::*;

  // ****************
  // exposure control
  // ****************
  logic [15:0] next_exposure;
  logic [7:0]  low_latch;
  eps_exposure_step u_step (
    .exposure      (exposure),
    .frame_max     (frame_max),
    .next_exposure (next_exposure)
  );
  // one update per frame; the step module clamps at the cap and the floor,
  // so the register never has to look at the brightness window itself
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) exposure <= EPS_EXP_RESET;
    else if (frame_tick) exposure <= next_exposure;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_latch <= EPS_EXP_RESET[7:0];
    else if (reg_read && reg_addr == EPS_ADDR_EXP_HIGH)
      low_latch <= exposure[7:0];
  end

  // ****************
  // pixel readout
  // ****************
  eps_pix_state_t pix_state;
  logic [8:0]     want;
  eps_pixel_t     pix;
  // a read hands over the held sample and rearms for the next index; the
  // index only advances when the read really carried a valid sample
  wire pix_read = reg_read && reg_addr == EPS_ADDR_PIXEL;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pix_state <= EPS_PIX_IDLE;
      want      <= 9'h000;
      pix       <= '0;
    end else if (reg_write && reg_addr == EPS_ADDR_PIXEL) begin
      pix_state <= EPS_PIX_ARMED;
      want      <= 9'h000;
      pix       <= '0;
    end else if (pix_read) begin
      pix.valid <= 1'b0;
      pix_state <= EPS_PIX_ARMED;
      if (pix.valid) begin
        if (want == EPS_SAMPLES - 9'h001) want <= 9'h000;
        else want <= want + 9'h001;
      end
    end else begin
      case (pix_state)
        EPS_PIX_ARMED: begin
          if (sample_strobe && sample_index == want) begin
            pix.code  <= sample_code;
            pix.start <= (want == 9'h000);
            pix.valid <= 1'b1;
            pix_state <= EPS_PIX_HELD;
          end
        end
        EPS_PIX_HELD: pix_state <= EPS_PIX_HELD;
        EPS_PIX_IDLE: pix_state <= EPS_PIX_IDLE;
        default: pix_state <= EPS_PIX_IDLE;
      endcase
    end
  end

  // ****************
  // read data
  // ****************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) reg_rdata <= 8'h00;
    else if (reg_read) begin
      case (reg_addr)
        EPS_ADDR_EXP_HIGH: reg_rdata <= exposure[15:8];
        EPS_ADDR_EXP_LOW:  reg_rdata <= low_latch;
        EPS_ADDR_INV_CODE: reg_rdata <= {4'h0, EPS_INV_CODE};
        EPS_ADDR_PIXEL:    reg_rdata <= pix;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  a_exp_cap: assert property (@(posedge clk) disable iff (!resetn)
    exposure <= EPS_EXP_MAX) else $error("exposure above cap");
  a_exp_hold: assert property (@(posedge clk) disable iff (!resetn)
    !frame_tick |=> exposure == $past(exposure))
    else $error("exposure moved off frame");
  a_low_pair: assert property (@(posedge clk) disable iff (!resetn)
    reg_read && reg_addr == EPS_ADDR_EXP_HIGH ##2
    reg_read && reg_addr == EPS_ADDR_EXP_LOW |=>
    reg_rdata == $past(exposure[7:0], 3))
    else $error("low byte not coherent");
  a_code_read: assert property (@(posedge clk) disable iff (!resetn)
    reg_read && reg_addr == EPS_ADDR_INV_CODE |=>
    reg_rdata == {4'h0, EPS_INV_CODE})
    else $error("bad part code");
  a_pix_rearm: assert property (@(posedge clk) disable iff (!resetn)
    reg_write && reg_addr == EPS_ADDR_PIXEL |=> want == 9'h000 && !pix.valid)
    else $error("pixel not rearmed");
  a_pix_range: assert property (@(posedge clk) disable iff (!resetn)
    want < EPS_SAMPLES) else $error("sample index out of range");

  // ****************
  // register read checks
  // ****************
  // the answer is registered, so each check looks one edge after the strobe
  a_high_read: assert property (@(posedge clk) disable iff (!resetn)
    reg_read && reg_addr == EPS_ADDR_EXP_HIGH |=>
    reg_rdata == $past(exposure[15:8]))
    else $error("high byte not the live exposure");

  a_latch_take: assert property (@(posedge clk) disable iff (!resetn)
    reg_read && reg_addr == EPS_ADDR_EXP_HIGH |=>
    low_latch == $past(exposure[7:0]))
    else $error("low byte not latched on high read");

  a_low_read: assert property (@(posedge clk) disable iff (!resetn)
    reg_read && reg_addr == EPS_ADDR_EXP_LOW |=>
    reg_rdata == $past(low_latch))
    else $error("low byte not from latch");

  a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    !reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
    reg_read && reg_addr != EPS_ADDR_EXP_HIGH &&
    reg_addr != EPS_ADDR_EXP_LOW && reg_addr != EPS_ADDR_INV_CODE &&
    reg_addr != EPS_ADDR_PIXEL |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ****************
  // exposure checks
  // ****************
  // the floor keeps a sixteenth step from collapsing to zero
  a_exp_floor: assert property (@(posedge clk) disable iff (!resetn)
    exposure >= EPS_EXP_MIN) else $error("exposure below floor");

  a_exp_rise: assert property (@(posedge clk) disable iff (!resetn)
    frame_tick && frame_max < EPS_BRIGHT_LO |=>
    exposure >= $past(exposure))
    else $error("dark frame lowered exposure");

  a_exp_fall: assert property (@(posedge clk) disable iff (!resetn)
    frame_tick && frame_max > EPS_BRIGHT_HI |=>
    exposure <= $past(exposure))
    else $error("bright frame raised exposure");

  a_exp_steady: assert property (@(posedge clk) disable iff (!resetn)
    frame_tick && frame_max >= EPS_BRIGHT_LO &&
    frame_max <= EPS_BRIGHT_HI |=> $stable(exposure))
    else $error("exposure moved inside window");

  // ****************
  // pixel checks
  // ****************
  a_pix_take: assert property (@(posedge clk) disable iff (!resetn)
    pix_state == EPS_PIX_ARMED && !pix_read &&
    !(reg_write && reg_addr == EPS_ADDR_PIXEL) &&
    sample_strobe && sample_index == want |=>
    pix.valid && pix.code == $past(sample_code))
    else $error("wanted sample not captured");

  a_pix_clear: assert property (@(posedge clk) disable iff (!resetn)
    pix_read |=> !pix.valid)
    else $error("valid flag survived a read");

  a_pix_start: assert property (@(posedge clk) disable iff (!resetn)
    pix.valid |-> pix.start == (want == 9'h000))
    else $error("frame start flag wrong");

  a_pix_data: assert property (@(posedge clk) disable iff (!resetn)
    pix_read |=> reg_rdata == $past(pix))
    else $error("pixel read data wrong");

  a_pix_step: assert property (@(posedge clk) disable iff (!resetn)
    pix_read && pix.valid && want != EPS_SAMPLES - 9'h001 |=>
    want == $past(want) + 9'h001)
    else $error("sample index did not advance");

  a_pix_wrap: assert property (@(posedge clk) disable iff (!resetn)
    pix_read && pix.valid && want == EPS_SAMPLES - 9'h001 |=>
    want == 9'h000)
    else $error("sample index did not wrap");
endmodule : eps_status_regs
`default_nettype wire

/* design/eps_pkg.sv */
// Purpose: constants and types for the exposure and pixel status block
// Assumes: one core clock at 24 MHz, registers reached by address/strobe
// Notes: addresses of the exposure high byte and pixel register are chosen
package eps_pkg;
  localparam logic [7:0]  EPS_ADDR_PIXEL    = 8'h08;
  localparam logic [7:0]  EPS_ADDR_EXP_HIGH = 8'h09;
  localparam logic [7:0]  EPS_ADDR_EXP_LOW  = 8'h0a;
  localparam logic [7:0]  EPS_ADDR_INV_CODE = 8'h11;
  localparam logic [15:0] EPS_EXP_RESET     = 16'h0100;
  localparam int          EPS_CORE_HZ       = 24000000;
  localparam int          EPS_EXP_MAX_INT   = EPS_CORE_HZ / 1500 - 3476;
  localparam logic [15:0] EPS_EXP_MAX       = EPS_EXP_MAX_INT[15:0];
  localparam logic [15:0] EPS_EXP_MIN       = 16'h0010;
  localparam int          EPS_FRAME_RATE    = 1512;
  localparam logic [5:0]  EPS_BRIGHT_HI     = 6'h39;
  localparam logic [5:0]  EPS_BRIGHT_LO     = 6'h33;
  localparam logic [8:0]  EPS_SAMPLES       = 9'h144;
  localparam logic [3:0]  EPS_INV_CODE      = 4'h5; // arbitrary value
  localparam int          EPS_SHIFT_SIXTEENTH = 4;

  typedef struct packed {
    logic       start;
    logic       valid;
    logic [5:0] code;
  } eps_pixel_t;

  typedef enum logic [1:0] {
    EPS_PIX_IDLE  = 2'b00,
    EPS_PIX_ARMED = 2'b01,
    EPS_PIX_HELD  = 2'b10
  } eps_pix_state_t;
endpackage : eps_pkg

/* design/eps_exposure_step.sv */
// Purpose: next exposure from frame brightness
// Assumes: called once per frame
// Notes: combinational
`timescale 1ns/100ps
`default_nettype none
module eps_exposure_step (
  // present state
  input  wire logic [15:0] exposure,
  input  wire logic [5:0]  frame_max,
  // result
  output logic [15:0]      next_exposure
);
  import eps_pkg::*;
  logic [15:0] step;
  logic [16:0] sum;
  always_comb begin
    step = exposure >> EPS_SHIFT_SIXTEENTH;
    sum  = {1'b0, exposure} + {1'b0, step};
    next_exposure = exposure;
    if (frame_max < EPS_BRIGHT_LO) begin
      if (sum > {1'b0, EPS_EXP_MAX}) next_exposure = EPS_EXP_MAX;
      else next_exposure = sum[15:0];
    end else if (frame_max > EPS_BRIGHT_HI) begin
      if (exposure - step < EPS_EXP_MIN) next_exposure = EPS_EXP_MIN;
      else next_exposure = exposure - step;
    end
  end
endmodule : eps_exposure_step
`default_nettype wire

/* tb/eps_ctrl_model.sv */
// Purpose: controller side model issuing register reads and writes
// Assumes: one access at a time with one cycle strobes
// Notes: strobes drop for one cycle between accesses
`timescale 1ns/100ps
`default_nettype none
module eps_ctrl_model (
  // clock
  input  wire logic  clk,
  // register access
  output logic       reg_read,
  output logic       reg_write,
  output logic [7:0] reg_addr
);
  initial begin
    reg_read  = 1'b0;
    reg_write = 1'b0;
    reg_addr  = 8'h00;
  end
  task automatic acc(input logic wr, input logic [7:0] a);
    @(posedge clk);
    reg_read  <= !wr;
    reg_write <= wr;
    reg_addr  <= a;
    @(posedge clk);
    reg_read  <= 1'b0;
    reg_write <= 1'b0;
    reg_addr  <= ~a; // a stale address is never left standing
  endtask : acc
endmodule : eps_ctrl_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: self-checking bench for the exposure and pixel status block
// Assumes: the controller model drives the register strobes
// Notes: expected read data waits in a queue until its answer cycle
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import eps_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, frame_tick = 1'b0, sample_strobe = 1'b0;
  logic [5:0]  frame_max = 6'h00, sample_code = 6'h00;
  logic [8:0]  sample_index = 9'h000;
  logic        reg_read, reg_write, rd_d = 1'b0;
  logic [7:0]  reg_addr, reg_rdata, lo;
  logic [15:0] exposure, qe, e_exp = EPS_EXP_RESET;
  logic [15:0] q[$];
  int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 741;
  always #5 clk = ~clk;
  eps_ctrl_model u_eps_ctrl_model (.clk(clk), .reg_read(reg_read),
    .reg_write(reg_write), .reg_addr(reg_addr));
  eps_status_regs u_eps_status_regs (.clk(clk), .resetn(resetn),
    .frame_tick(frame_tick), .frame_max(frame_max),
    .sample_strobe(sample_strobe), .sample_index(sample_index),
    .sample_code(sample_code), .reg_read(reg_read), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .exposure(exposure));
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, m, e);
    q.push_back({m, e});
    u_eps_ctrl_model.acc(1'b0, a);
  endtask : rd
  task automatic tick(input logic [5:0] fm);
    @(posedge clk);
    frame_tick <= 1'b1;
    frame_max  <= fm;
    @(posedge clk);
    frame_tick <= 1'b0;
    if (fm < EPS_BRIGHT_LO) e_exp = e_exp + (e_exp >> 4);
    if (fm > EPS_BRIGHT_HI) e_exp = e_exp - (e_exp >> 4);
    if (e_exp > EPS_EXP_MAX) e_exp = EPS_EXP_MAX;
    if (e_exp < EPS_EXP_MIN) e_exp = EPS_EXP_MIN;
    @(negedge clk);
    chk("exposure", e_exp, exposure);
  endtask : tick
  task automatic smp(input logic [8:0] i, input logic [5:0] c);
    @(posedge clk);
    sample_strobe <= 1'b1;
    sample_index  <= i;
    sample_code   <= c;
    @(posedge clk);
    sample_strobe <= 1'b0;
  endtask : smp
  // answer lands one cycle after the read strobe
  always @(posedge clk) begin
    rd_d <= reg_read;
    cyc  <= cyc + 1;
    if (rd_d) begin
      qe = q.pop_front();
      chk("rdata", {8'h00, qe[7:0]}, {8'h00, reg_rdata & qe[15:8]});
    end
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    chk("exposure", EPS_EXP_RESET, exposure);
    rd(EPS_ADDR_EXP_HIGH, 8'hff, 8'h01);
    rd(EPS_ADDR_EXP_LOW, 8'hff, 8'h00);
    rd(EPS_ADDR_INV_CODE, 8'h0f, {4'h0, EPS_INV_CODE});
    rd(8'h00, 8'hff, 8'h00);
    for (int i = 0; i < 150; i++)
      tick(i < 90 ? 6'($unsigned($random(seed)) % 51) : 6'($random(seed)));
    rd(EPS_ADDR_EXP_HIGH, 8'hff, e_exp[15:8]);
    lo = e_exp[7:0];
    tick(6'h3f);
    rd(EPS_ADDR_EXP_LOW, 8'hff, lo);
    u_eps_ctrl_model.acc(1'b1, EPS_ADDR_PIXEL);
    smp(9'd5, 6'h2a);
    smp(9'd0, 6'h15);
    rd(EPS_ADDR_PIXEL, 8'hff, 8'hd5);
    smp(9'd1, 6'h3c);
    rd(EPS_ADDR_PIXEL, 8'hff, 8'h7c);
    rd(EPS_ADDR_PIXEL, 8'h40, 8'h00);
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
